// File: hdl/asgc_pkg.sv
// Shared constants, types and register map of the converter control core
package asgc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_DATARATE = 8'h04;
  localparam logic [7:0] REG_SYSCTRL = 8'h09;
  localparam logic [7:0] REG_OFC_LO = 8'h0A;
  localparam logic [7:0] REG_OFC_HI = 8'h0B;
  localparam logic [7:0] REG_FSC_LO = 8'h0C;
  localparam logic [7:0] REG_FSC_HI = 8'h0D;
  localparam logic [7:0] REG_PORT_DATA = 8'h10;
  localparam logic [7:0] REG_PORT_SEL = 8'h11;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_POR_BIT = 7;
  localparam int STAT_NRDY_BIT = 6;
  localparam int DR_MODE_BIT = 5;
  localparam int DR_EXTCLK_BIT = 6;
  localparam int SYS_MON_LSB = 0;
  localparam int SYS_AVG_LSB = 3;
  localparam int SYS_CHOP_BIT = 5;
  localparam logic [7:0] DATARATE_RST = 8'h00;
  localparam logic [7:0] SYSCTRL_RST = 8'h00;
  localparam logic [7:0] PORT_DATA_RST = 8'hF0;
  localparam logic [7:0] PORT_SEL_RST = 8'h00;
  localparam logic [15:0] OFC_RST = 16'h0000;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam int GAIN_SHIFT = 14;
  localparam logic [15:0] FULL_SCALE = 16'h7FFF;
  localparam logic [15:0] NEG_FULL_SCALE = 16'h8000;
  localparam logic [2:0] MON_MIDSCALE = 3'h1;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WAKE = 8'h02;
  localparam logic [7:0] CMD_SLEEP = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_STOP = 8'h0A;
  localparam logic [7:0] CMD_SYS_OFS = 8'h16;
  localparam logic [7:0] CMD_SYS_GAIN = 8'h17;
  localparam logic [7:0] CMD_SELF_OFS = 8'h19;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_TIME_US = 2200;
  localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
  localparam int STROBE_LOW_TIME_NS = 500;
  localparam int STROBE_LOW_CYCLES = (STROBE_LOW_TIME_NS * CLK_MHZ) / 1000;
  localparam int DIV_STEPS = 29;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_NONE = 2'b00,
    REQ_WRITE = 2'b01,
    REQ_READ = 2'b10,
    REQ_CMD = 2'b11
  } asgc_req_kind_t;

  typedef struct packed {
    asgc_req_kind_t kind;
    logic [7:0] addr;
    logic [7:0] data;
  } asgc_req_t;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_CONV = 3'b001,
    ST_CAL = 3'b010,
    ST_DIV = 3'b011,
    ST_PWRDN = 3'b100
  } asgc_state_t;

  typedef enum logic [1:0] {
    CAL_SELF_OFS = 2'b00,
    CAL_SYS_OFS = 2'b01,
    CAL_SYS_GAIN = 2'b10
  } asgc_cal_t;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] val;
  } asgc_port_t;

endpackage

// File: hdl/asgc_core.sv
// Converter control core: status, port pins, calibration, mode sequencing, resets

module asgc_core #(
  parameter int STARTUP_CYCLES = asgc_pkg::STARTUP_CYCLES,
  parameter int STROBE_LOW_CYCLES = asgc_pkg::STROBE_LOW_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic link_req_valid_in,
  input wire asgc_pkg::asgc_req_t link_req_in,
  output logic link_busy_out,
  output logic link_done_out,
  output logic [7:0] link_rdata_out,
  input wire logic reset_pin_n_in,
  input wire logic trigger_pin_in,
  input wire logic filt_valid_in,
  input wire logic [15:0] filt_data_in,
  output logic [15:0] result_out,
  output logic result_ready_strobe_n_out,
  output logic conv_run_out,
  output logic conv_restart_out,
  output logic power_down_out,
  output logic osc_internal_out,
  output logic [2:0] monitor_select_out,
  output logic [3:0] pin_select_bits_out,
  input wire logic [3:0] gpio_pin_in,
  output logic [3:0] gpio_pin_out,
  output logic [3:0] gpio_pin_oe_out
);

  // ----------------------------------------------------------------
  // Link domain: capture request, toggle toward core
  // ----------------------------------------------------------------
  asgc_pkg::asgc_req_t lk_req_q, lk_req_d;
  logic lk_busy_q, lk_busy_d;
  logic lk_tgl_q, lk_tgl_d;
  logic lk_done_q, lk_done_d;
  logic [7:0] lk_rdata_q, lk_rdata_d;
  logic lk_ack_s1_q, lk_ack_s2_q, lk_ack_seen_q, lk_ack_seen_d;
  logic core_ack_tgl_q;
  logic [7:0] core_rdata_q;

  always_comb
  begin
    lk_req_d = lk_req_q;
    lk_busy_d = lk_busy_q;
    lk_tgl_d = lk_tgl_q;
    lk_done_d = 1'b0;
    lk_rdata_d = lk_rdata_q;
    lk_ack_seen_d = lk_ack_seen_q;
    if (lk_busy_q && (lk_ack_s2_q != lk_ack_seen_q))
    begin
      // Core data was registered on the same edge that toggled its ack
      lk_busy_d = 1'b0;
      lk_done_d = 1'b1;
      lk_rdata_d = core_rdata_q;
      lk_ack_seen_d = lk_ack_s2_q;
    end
    else if (!lk_busy_q && link_req_valid_in)
    begin
      lk_req_d = link_req_in;
      lk_tgl_d = ~lk_tgl_q;
      lk_busy_d = 1'b1;
    end
  end

  always_ff @(posedge link_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lk_req_q <= '0;
      lk_busy_q <= 1'b0;
      lk_tgl_q <= 1'b0;
      lk_done_q <= 1'b0;
      lk_rdata_q <= 8'h00;
      lk_ack_s1_q <= 1'b0;
      lk_ack_s2_q <= 1'b0;
      lk_ack_seen_q <= 1'b0;
    end
    else
    begin
      lk_req_q <= lk_req_d;
      lk_busy_q <= lk_busy_d;
      lk_tgl_q <= lk_tgl_d;
      lk_done_q <= lk_done_d;
      lk_rdata_q <= lk_rdata_d;
      lk_ack_s1_q <= core_ack_tgl_q;
      lk_ack_s2_q <= lk_ack_s1_q;
      lk_ack_seen_q <= lk_ack_seen_d;
    end
  end

  assign link_busy_out = lk_busy_q;
  assign link_done_out = lk_done_q;
  assign link_rdata_out = lk_rdata_q;

  // ----------------------------------------------------------------
  // Core synchronisers
  // ----------------------------------------------------------------
  logic rq_s1_q, rq_s2_q, rq_seen_q;
  logic rst_s1_q, rst_s2_q;
  logic trg_s1_q, trg_s2_q, trg_prev_q;
  logic [3:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_prev_q <= 1'b0;
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else
    begin
      rq_s1_q <= lk_tgl_q;
      rq_s2_q <= rq_s1_q;
      rst_s1_q <= reset_pin_n_in;
      rst_s2_q <= rst_s1_q;
      trg_s1_q <= trigger_pin_in;
      trg_s2_q <= trg_s1_q;
      trg_prev_q <= trg_s2_q;
      pin_s1_q <= gpio_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  asgc_pkg::asgc_state_t state_q, state_d;
  asgc_pkg::asgc_cal_t cal_q, cal_d;
  logic por_q, por_d;
  logic nrdy_q, nrdy_d;
  logic [31:0] boot_cnt_q, boot_cnt_d;
  logic [7:0] datarate_q, datarate_d;
  logic [7:0] sysctrl_q, sysctrl_d;
  logic [15:0] ofc_q, ofc_d;
  logic [15:0] fsc_q, fsc_d;
  asgc_pkg::asgc_port_t port_q, port_d;
  logic [7:0] port_sel_q, port_sel_d;
  logic rq_seen_d, ack_tgl_d;
  logic [7:0] rdata_d;
  logic [7:0] cmd_p1_q, cmd_p1_d, cmd_p2_q;
  logic [1:0] trg_rise_q, trg_fall_q;
  logic stop_pend_q, stop_pend_d;
  logic restart_q, restart_d;
  logic [15:0] result_q, result_d;
  logic [7:0] strobe_cnt_q, strobe_cnt_d;
  logic [4:0] cal_cnt_q, cal_cnt_d;
  logic [19:0] acc_q, acc_d;
  logic [17:0] rem_q, rem_d;
  logic [28:0] quo_q, quo_d;
  logic [16:0] divisor_q, divisor_d;
  logic [4:0] div_cnt_q, div_cnt_d;

  // ----------------------------------------------------------------
  // Datapath: correction, averaging, divide step
  // ----------------------------------------------------------------
  logic [3:0] port_rd;
  logic [16:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic [15:0] corrected;
  logic [4:0] avg_n;
  logic [19:0] acc_next;
  logic [15:0] avg;
  logic [17:0] rem_sh;
  logic [16:0] gain_div;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      // Direction bit 1 means input
      assign port_rd[gi] = port_q.dir[gi] ? pin_s2_q[gi] : port_q.val[gi];
      assign gpio_pin_oe_out[gi] = port_sel_q[gi] & ~port_q.dir[gi];
      assign gpio_pin_out[gi] = port_q.val[gi];
    end
  endgenerate

  always_comb
  begin
    // Chop mode drops the offset term from the result correction; gain_div still subtracts it
    if (sysctrl_q[asgc_pkg::SYS_CHOP_BIT])
      diff = {filt_data_in[15], filt_data_in};
    else
      diff = {filt_data_in[15], filt_data_in} - {ofc_q[15], ofc_q};
    prod = $signed(diff) * $signed({1'b0, fsc_q});
    scaled = prod >>> asgc_pkg::GAIN_SHIFT;
    if (scaled > $signed({18'h00000, asgc_pkg::FULL_SCALE}))
      corrected = asgc_pkg::FULL_SCALE;
    else if (scaled < $signed({18'h3FFFF, asgc_pkg::NEG_FULL_SCALE}))
      corrected = asgc_pkg::NEG_FULL_SCALE;
    else
      corrected = scaled[15:0];
  end

  always_comb
  begin
    acc_next = acc_q + {{4{filt_data_in[15]}}, filt_data_in};
    unique case (sysctrl_q[asgc_pkg::SYS_AVG_LSB +: 2])
      2'b00:
      begin
        avg_n = 5'h01;
        avg = acc_next[15:0];
      end
      2'b01:
      begin
        avg_n = 5'h04;
        avg = acc_next[17:2];
      end
      2'b10:
      begin
        avg_n = 5'h08;
        avg = acc_next[18:3];
      end
      2'b11:
      begin
        avg_n = 5'h10;
        avg = acc_next[19:4];
      end
    endcase
    gain_div = {avg[15], avg} - {ofc_q[15], ofc_q};
    rem_sh = {rem_q[16:0], quo_q[28]};
  end

  // ----------------------------------------------------------------
  // Core next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic soft_rst;
    logic req_new;
    logic start_ev;
    logic stop_ev;
    logic cal_ev;
    asgc_pkg::asgc_cal_t cal_kind;
    soft_rst = 1'b0;
    req_new = (rq_s2_q != rq_seen_q);
    state_d = state_q;
    cal_d = cal_q;
    por_d = por_q;
    nrdy_d = nrdy_q;
    boot_cnt_d = boot_cnt_q;
    datarate_d = datarate_q;
    sysctrl_d = sysctrl_q;
    ofc_d = ofc_q;
    fsc_d = fsc_q;
    port_d = port_q;
    port_sel_d = port_sel_q;
    rq_seen_d = rq_s2_q;
    ack_tgl_d = core_ack_tgl_q;
    rdata_d = core_rdata_q;
    cmd_p1_d = 8'h00;
    stop_pend_d = stop_pend_q;
    restart_d = 1'b0;
    result_d = result_q;
    strobe_cnt_d = (strobe_cnt_q != 8'h00) ? strobe_cnt_q - 8'h01 : 8'h00;
    cal_cnt_d = cal_cnt_q;
    acc_d = acc_q;
    rem_d = rem_q;
    quo_d = quo_q;
    divisor_d = divisor_q;
    div_cnt_d = div_cnt_q;
    cal_kind = asgc_pkg::CAL_SELF_OFS;
    cal_ev = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;

    // Start-up delay before configuration is accepted
    if (nrdy_q)
    begin
      if (boot_cnt_q >= 32'(STARTUP_CYCLES - 1))
        nrdy_d = 1'b0;
      else
        boot_cnt_d = boot_cnt_q + 32'h00000001;
    end

    // Register and command requests from the link
    if (req_new)
    begin
      ack_tgl_d = ~core_ack_tgl_q;
      unique case (lk_req_q.kind)
        asgc_pkg::REQ_READ:
        begin
          unique case (lk_req_q.addr)
            asgc_pkg::REG_STATUS: rdata_d = {por_q, nrdy_q, 6'h00};
            asgc_pkg::REG_DATARATE: rdata_d = datarate_q;
            asgc_pkg::REG_SYSCTRL: rdata_d = sysctrl_q;
            asgc_pkg::REG_OFC_LO: rdata_d = ofc_q[7:0];
            asgc_pkg::REG_OFC_HI: rdata_d = ofc_q[15:8];
            asgc_pkg::REG_FSC_LO: rdata_d = fsc_q[7:0];
            asgc_pkg::REG_FSC_HI: rdata_d = fsc_q[15:8];
            asgc_pkg::REG_PORT_DATA: rdata_d = {port_q.dir, port_rd};
            asgc_pkg::REG_PORT_SEL: rdata_d = port_sel_q;
            default: rdata_d = 8'h00;
          endcase
        end
        asgc_pkg::REQ_WRITE:
        begin
          // Writes dropped while starting up or powered down
          if (!nrdy_q && state_q != asgc_pkg::ST_PWRDN)
          begin
            unique case (lk_req_q.addr)
              asgc_pkg::REG_STATUS:
                if (!lk_req_q.data[asgc_pkg::STAT_POR_BIT])
                  por_d = 1'b0;
              asgc_pkg::REG_DATARATE: datarate_d = lk_req_q.data;
              asgc_pkg::REG_SYSCTRL: sysctrl_d = lk_req_q.data;
              asgc_pkg::REG_OFC_LO: ofc_d[7:0] = lk_req_q.data;
              asgc_pkg::REG_OFC_HI: ofc_d[15:8] = lk_req_q.data;
              asgc_pkg::REG_FSC_LO: fsc_d[7:0] = lk_req_q.data;
              asgc_pkg::REG_FSC_HI: fsc_d[15:8] = lk_req_q.data;
              asgc_pkg::REG_PORT_DATA: port_d = lk_req_q.data;
              asgc_pkg::REG_PORT_SEL: port_sel_d = {4'h0, lk_req_q.data[3:0]};
              default: ;
            endcase
          end
        end
        asgc_pkg::REQ_CMD: cmd_p1_d = lk_req_q.data;
        default: ;
      endcase
    end

    // Commands and trigger edges act after the two-stage delay
    start_ev = (cmd_p2_q == asgc_pkg::CMD_START) | trg_rise_q[1];
    stop_ev = (cmd_p2_q == asgc_pkg::CMD_STOP) | trg_fall_q[1];
    if (cmd_p2_q == asgc_pkg::CMD_SELF_OFS)
    begin
      cal_ev = 1'b1;
      cal_kind = asgc_pkg::CAL_SELF_OFS;
    end
    else if (cmd_p2_q == asgc_pkg::CMD_SYS_OFS)
    begin
      cal_ev = 1'b1;
      cal_kind = asgc_pkg::CAL_SYS_OFS;
    end
    else if (cmd_p2_q == asgc_pkg::CMD_SYS_GAIN)
    begin
      cal_ev = 1'b1;
      cal_kind = asgc_pkg::CAL_SYS_GAIN;
    end

    unique case (state_q)
      asgc_pkg::ST_PWRDN:
        if (cmd_p2_q == asgc_pkg::CMD_WAKE)
          state_d = asgc_pkg::ST_STANDBY;
      asgc_pkg::ST_STANDBY:
        // Calibration requests simply fall away here
        if (start_ev)
        begin
          state_d = asgc_pkg::ST_CONV;
          restart_d = 1'b1;
          stop_pend_d = 1'b0;
        end
      asgc_pkg::ST_CONV:
      begin
        if (start_ev)
        begin
          restart_d = 1'b1;
          stop_pend_d = 1'b0;
        end
        else if (cal_ev)
        begin
          state_d = asgc_pkg::ST_CAL;
          cal_d = cal_kind;
          restart_d = 1'b1;
          cal_cnt_d = 5'h00;
          acc_d = 20'h00000;
        end
        else
        begin
          if (stop_ev)
            stop_pend_d = 1'b1;
          if (filt_valid_in)
          begin
            result_d = corrected;
            strobe_cnt_d = 8'(STROBE_LOW_CYCLES);
            if (datarate_q[asgc_pkg::DR_MODE_BIT] || stop_pend_q || stop_ev)
              state_d = asgc_pkg::ST_STANDBY;
          end
        end
      end
      asgc_pkg::ST_CAL:
        if (filt_valid_in)
        begin
          acc_d = acc_next;
          cal_cnt_d = cal_cnt_q + 5'h01;
          if (cal_cnt_q + 5'h01 == avg_n)
          begin
            if (cal_q == asgc_pkg::CAL_SYS_GAIN)
            begin
              if ($signed(gain_div) > 0)
              begin
                state_d = asgc_pkg::ST_DIV;
                divisor_d = gain_div;
                rem_d = 18'h00000;
                quo_d = {asgc_pkg::FULL_SCALE[14:0], 14'h0000};
                div_cnt_d = 5'h00;
              end
              else
              begin
                state_d = asgc_pkg::ST_CONV;
                restart_d = 1'b1;
              end
            end
            else
            begin
              ofc_d = avg;
              state_d = asgc_pkg::ST_CONV;
              restart_d = 1'b1;
            end
          end
        end
      asgc_pkg::ST_DIV:
      begin
        // Bit-serial divide keeps the gain solve small
        if (rem_sh >= {1'b0, divisor_q})
        begin
          rem_d = rem_sh - {1'b0, divisor_q};
          quo_d = {quo_q[27:0], 1'b1};
        end
        else
        begin
          rem_d = rem_sh;
          quo_d = {quo_q[27:0], 1'b0};
        end
        div_cnt_d = div_cnt_q + 5'h01;
        if (div_cnt_q == 5'(asgc_pkg::DIV_STEPS - 1))
        begin
          fsc_d = (quo_d[28:16] != 13'h0000) ? 16'hFFFF : quo_d[15:0];
          state_d = asgc_pkg::ST_CONV;
          restart_d = 1'b1;
        end
      end
      default: state_d = asgc_pkg::ST_STANDBY;
    endcase

    if (cmd_p2_q == asgc_pkg::CMD_SLEEP && state_q != asgc_pkg::ST_PWRDN)
    begin
      state_d = asgc_pkg::ST_PWRDN;
      restart_d = 1'b0;
      stop_pend_d = 1'b0;
    end

    // Reset command is deaf in power-down, pin reset is not
    soft_rst = !rst_s2_q || (cmd_p2_q == asgc_pkg::CMD_RESET && state_q != asgc_pkg::ST_PWRDN);
    if (soft_rst)
    begin
      state_d = asgc_pkg::ST_STANDBY;
      nrdy_d = 1'b1;
      boot_cnt_d = 32'h00000000;
      datarate_d = asgc_pkg::DATARATE_RST;
      sysctrl_d = asgc_pkg::SYSCTRL_RST;
      ofc_d = asgc_pkg::OFC_RST;
      fsc_d = asgc_pkg::GAIN_UNITY;
      port_d = asgc_pkg::PORT_DATA_RST;
      port_sel_d = asgc_pkg::PORT_SEL_RST;
      stop_pend_d = 1'b0;
      restart_d = 1'b0;
      strobe_cnt_d = 8'h00;
      cmd_p1_d = 8'h00;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= asgc_pkg::ST_STANDBY;
      cal_q <= asgc_pkg::CAL_SELF_OFS;
      por_q <= 1'b1;
      nrdy_q <= 1'b1;
      boot_cnt_q <= 32'h00000000;
      datarate_q <= asgc_pkg::DATARATE_RST;
      sysctrl_q <= asgc_pkg::SYSCTRL_RST;
      ofc_q <= asgc_pkg::OFC_RST;
      fsc_q <= asgc_pkg::GAIN_UNITY;
      port_q <= asgc_pkg::PORT_DATA_RST;
      port_sel_q <= asgc_pkg::PORT_SEL_RST;
      rq_seen_q <= 1'b0;
      core_ack_tgl_q <= 1'b0;
      core_rdata_q <= 8'h00;
      cmd_p1_q <= 8'h00;
      cmd_p2_q <= 8'h00;
      trg_rise_q <= 2'b00;
      trg_fall_q <= 2'b00;
      stop_pend_q <= 1'b0;
      restart_q <= 1'b0;
      result_q <= 16'h0000;
      strobe_cnt_q <= 8'h00;
      cal_cnt_q <= 5'h00;
      acc_q <= 20'h00000;
      rem_q <= 18'h00000;
      quo_q <= 29'h00000000;
      divisor_q <= 17'h00000;
      div_cnt_q <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
      cal_q <= cal_d;
      por_q <= por_d;
      nrdy_q <= nrdy_d;
      boot_cnt_q <= boot_cnt_d;
      datarate_q <= datarate_d;
      sysctrl_q <= sysctrl_d;
      ofc_q <= ofc_d;
      fsc_q <= fsc_d;
      port_q <= port_d;
      port_sel_q <= port_sel_d;
      rq_seen_q <= rq_seen_d;
      core_ack_tgl_q <= ack_tgl_d;
      core_rdata_q <= rdata_d;
      cmd_p1_q <= cmd_p1_d;
      cmd_p2_q <= cmd_p1_q;
      trg_rise_q <= {trg_rise_q[0], trg_s2_q & ~trg_prev_q};
      trg_fall_q <= {trg_fall_q[0], ~trg_s2_q & trg_prev_q};
      stop_pend_q <= stop_pend_d;
      restart_q <= restart_d;
      result_q <= result_d;
      strobe_cnt_q <= strobe_cnt_d;
      cal_cnt_q <= cal_cnt_d;
      acc_q <= acc_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      divisor_q <= divisor_d;
      div_cnt_q <= div_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign result_out = result_q;
  assign result_ready_strobe_n_out = (strobe_cnt_q == 8'h00);
  assign conv_run_out = (state_q == asgc_pkg::ST_CONV) || (state_q == asgc_pkg::ST_CAL);
  assign conv_restart_out = restart_q;
  assign power_down_out = (state_q == asgc_pkg::ST_PWRDN);
  assign osc_internal_out = ~datarate_q[asgc_pkg::DR_EXTCLK_BIT];
  assign monitor_select_out = (state_q == asgc_pkg::ST_CAL && cal_q == asgc_pkg::CAL_SELF_OFS)
    ? asgc_pkg::MON_MIDSCALE : sysctrl_q[asgc_pkg::SYS_MON_LSB +: 3];
  assign pin_select_bits_out = port_sel_q[3:0];

endmodule

// File: tb/asgc_core_props.sv
// Assertion checker for the converter control core
module asgc_core_props #(parameter int STROBE_LOW_CYCLES = 50) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic filt_valid_in,
  input wire logic [15:0] result_out,
  input wire logic result_ready_strobe_n_out,
  input wire logic conv_run_out,
  input wire logic conv_restart_out,
  input wire logic power_down_out,
  input wire logic osc_internal_out,
  input wire logic [3:0] pin_select_bits_out,
  input wire logic [3:0] gpio_pin_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (reset_in);
  int low_q;
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
      low_q <= 0;
    else
      low_q <= result_ready_strobe_n_out ? 0 : low_q + 1;
  strobe_len_a: assert property ($rose(result_ready_strobe_n_out) |-> low_q == STROBE_LOW_CYCLES)
    else $error("strobe width");
  strobe_src_a: assert property ($fell(result_ready_strobe_n_out) |-> $past(filt_valid_in))
    else $error("strobe cause");
  oe_sel_a: assert property ((gpio_pin_oe_out & ~pin_select_bits_out) == 4'h0)
    else $error("oe");
  sleep_run_a: assert property (power_down_out |-> !conv_run_out)
    else $error("sleep run");
  sleep_hold_a: assert property (power_down_out && filt_valid_in |=> $stable(result_out))
    else $error("hold");
  restart_pulse_a: assert property (conv_restart_out |=> !conv_restart_out)
    else $error("restart");
  run_restart_a: assert property ($rose(conv_run_out) |-> ##[0:3] conv_restart_out)
    else $error("start");
  reset_state_a: assert property ($fell(reset_in) |-> osc_internal_out && !conv_run_out && !power_down_out)
    else $error("reset state");
endmodule

bind asgc_core asgc_core_props #(.STROBE_LOW_CYCLES(STROBE_LOW_CYCLES)) props (.clk_in, .reset_in,
  .filt_valid_in, .result_out, .result_ready_strobe_n_out, .conv_run_out, .conv_restart_out,
  .power_down_out, .osc_internal_out, .pin_select_bits_out, .gpio_pin_oe_out);

// File: tb/asgc_host.sv
// Host model issuing register and command requests over the link
module asgc_host (
  input wire logic link_clk_in,
  input wire logic done_in,
  input wire logic [7:0] rdata_in,
  output logic valid_out = 1'b0,
  output asgc_pkg::asgc_req_t req_out = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  // One request outstanding; released fields show inverted junk, not stale data
  task automatic xfer(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge link_clk_in);
    valid_out <= 1'b1;
    req_out <= {k, a, d};
    @(posedge link_clk_in);
    valid_out <= 1'b0;
    req_out <= ~req_out;
    n = 0;
    while (done_in !== 1'b1 && n < 40)
    begin
      @(posedge link_clk_in);
      n++;
    end
    // A link that never answers counts against the run
    if (n >= 40)
      test_adc_status_gpio_calibration_ctrl.bad_count++;
    q = rdata_in;
  endtask
endmodule

// File: tb/test_adc_status_gpio_calibration_ctrl.sv
// Self-checking bench for the converter control core
module test_adc_status_gpio_calibration_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [3:0] oe;} asgc_row_t;
  asgc_row_t rows [7] = '{'{8'h01, 8'hFF, 8'h80, 4'h0}, '{8'h01, 8'h00, 8'h00, 4'h0},
    '{8'h11, 8'h0F, 8'h0F, 4'h0}, '{8'h10, 8'h05, 8'h05, 4'hF}, '{8'h10, 8'hF0, 8'hFA, 4'h0},
    '{8'h0A, 8'h10, 8'h10, 4'h0}, '{8'h0D, 8'h80, 8'h80, 4'h0}};
  logic clk_in = 0, lclk = 0, reset_in = 1, rpin_n = 1, trig = 0, fv = 0, busy, done, vld;
  logic run, rst, pdn, osc, stb_n;
  logic [15:0] fd = 16'h0000, result;
  logic [7:0] rdata, q;
  logic [2:0] mon;
  logic [3:0] sel, gout, goe;
  asgc_pkg::asgc_req_t req;
  int bad_count = 0, num_checks = 0, cyc = 0;
  initial forever #5 clk_in = ~clk_in;
  initial
  begin
    #3;
    forever #40 lclk = ~lclk;
  end
  asgc_core #(.STARTUP_CYCLES(20), .STROBE_LOW_CYCLES(4)) DUT (.clk_in, .reset_in, .link_clk_in(lclk),
    .link_req_valid_in(vld), .link_req_in(req), .link_busy_out(busy), .link_done_out(done),
    .link_rdata_out(rdata), .reset_pin_n_in(rpin_n), .trigger_pin_in(trig), .filt_valid_in(fv),
    .filt_data_in(fd), .result_out(result), .result_ready_strobe_n_out(stb_n), .conv_run_out(run),
    .conv_restart_out(rst), .power_down_out(pdn), .osc_internal_out(osc), .monitor_select_out(mon),
    .pin_select_bits_out(sel), .gpio_pin_in(4'hA), .gpio_pin_out(gout), .gpio_pin_oe_out(goe));
  asgc_host host (.link_clk_in(lclk), .done_in(done), .rdata_in(rdata), .valid_out(vld), .req_out(req));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      bad_count++;
    end
    num_checks++;
  endtask
  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic feed(input logic [15:0] d, input logic [15:0] e, input logic c);
    @(posedge clk_in);
    fv <= 1;
    fd <= d;
    @(posedge clk_in);
    fv <= 0;
    fd <= ~d;
    repeat (2) @(posedge clk_in);
    if (c)
      chk("res", result, e);
    repeat (8) @(posedge clk_in);
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      end_sim;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    repeat (30) @(posedge clk_in);
    foreach (rows[i])
    begin
      host.xfer(2'd1, rows[i].a, rows[i].w, q);
      host.xfer(2'd2, rows[i].a, 8'h00, q);
      chk("reg", {8'h00, q}, {8'h00, rows[i].r});
      chk("pin", {7'h00, busy, goe, gout & goe}, {8'h00, rows[i].oe, rows[i].r[3:0] & rows[i].oe});
    end
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_START, q);
    feed(16'h0110, 16'h0200, 1);
    feed(16'h7000, asgc_pkg::FULL_SCALE, 1);
    feed(16'h8000, asgc_pkg::NEG_FULL_SCALE, 1);
    host.xfer(2'd1, 8'h04, 8'h20, q);
    feed(16'h0010, 16'h0000, 1);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_SELF_OFS, q);
    chk("idle", {15'h0, run}, 16'h0);
    host.xfer(2'd1, 8'h04, 8'h00, q);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_START, q);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_SELF_OFS, q);
    chk("mon", {13'h0, mon}, {13'h0, asgc_pkg::MON_MIDSCALE});
    feed(16'h0020, 16'h0000, 0);
    feed(16'h0030, 16'h0020, 1);
    // Chop on, four-reading average; system offset ahead of system gain
    host.xfer(2'd1, 8'h09, 8'h28, q);
    feed(16'h0100, 16'h0200, 1);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_SYS_OFS, q);
    chk("mon", {13'h0, mon}, 16'h0000);
    repeat (2) feed(16'h0010, 16'h0000, 0);
    repeat (2) feed(16'h0018, 16'h0000, 0);
    host.xfer(2'd2, 8'h0A, 8'h00, q);
    chk("ofs", {8'h00, q}, 16'h0014);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_SYS_GAIN, q);
    repeat (4) feed(16'h4014, 16'h0000, 0);
    // Gain divide needs 29 cycles before the word is readable
    repeat (30) @(posedge clk_in);
    host.xfer(2'd2, 8'h0C, 8'h00, q);
    chk("gain", {8'h00, q}, 16'h00FF);
    feed(16'h2000, 16'h3FFF, 1);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_STOP, q);
    feed(16'h0000, 16'h0000, 1);
    chk("stop", {15'h0, run}, 16'h0);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_RESET, q);
    host.xfer(2'd2, 8'h0D, 8'h00, q);
    chk("rcmd", {8'h00, q}, 16'h0040);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_SLEEP, q);
    chk("pdn", {14'h0, pdn, run}, 16'h2);
    feed(16'h1234, 16'h0000, 0);
    host.xfer(2'd3, 8'h00, asgc_pkg::CMD_WAKE, q);
    @(posedge clk_in);
    trig <= 1;
    repeat (8) @(posedge clk_in);
    chk("trig", {14'h0, pdn, run}, 16'h1);
    rpin_n <= 0;
    repeat (10) @(posedge clk_in);
    rpin_n <= 1;
    repeat (30) @(posedge clk_in);
    host.xfer(2'd2, 8'h11, 8'h00, q);
    chk("rpin", {5'h0, osc, pdn, run, q}, 16'h0400);
    end_sim;
  end
endmodule
